/* File: design/clock_manager_pkg.sv */
// package: register map, field layout and constants of the clock manager
`default_nettype none
package clock_manager_pkg;
    // register byte offsets
    localparam logic [7:0] SYSCLK_GATE_ON_REG    = 8'h00;
    localparam logic [7:0] SYSCLK_GATE_OFF_REG   = 8'h04;
    localparam logic [7:0] SYSCLK_GATE_STATE_REG = 8'h08;
    localparam logic [7:0] PERIPH_GATE_ON_REG    = 8'h10;
    localparam logic [7:0] PERIPH_GATE_OFF_REG   = 8'h14;
    localparam logic [7:0] PERIPH_GATE_STATE_REG = 8'h18;
    localparam logic [7:0] CRYSTAL_OSC_REG       = 8'h20;
    localparam logic [7:0] FREQ_MEAS_REG         = 8'h24;
    localparam logic [7:0] PLL_CONFIG_REG        = 8'h2C;
    localparam logic [7:0] SYSCLK_CONFIG_REG     = 8'h30;
    localparam logic [7:0] EXT_CLOCK_CONFIG_REG0 = 8'h40;
    localparam logic [7:0] EXT_CLOCK_CONFIG_REG1 = 8'h44;
    localparam logic [7:0] EXT_CLOCK_CONFIG_REG2 = 8'h48;
    localparam logic [7:0] CLOCK_IRQ_ENABLE_REG  = 8'h60;
    localparam logic [7:0] CLOCK_IRQ_DISABLE_REG = 8'h64;
    localparam logic [7:0] CLOCK_STATUS_REG      = 8'h68;
    localparam logic [7:0] CLOCK_IRQ_MASK_REG    = 8'h6C;
    // field positions
    localparam int SRC_LSB      = 0;
    localparam int RATIO_LSB    = 2;
    localparam int CPU_BIT      = 0;
    localparam int EXT_LSB      = 8;
    localparam int OSC_EN_BIT   = 0;
    localparam int OSC_CNT_LSB  = 8;
    localparam int PLL_RAT_LSB  = 0;
    localparam int PLL_CNT_LSB  = 8;
    localparam int PLL_FAC_LSB  = 16;
    localparam int MEAS_RDY_BIT = 16;
    localparam int ST_XTAL_BIT  = 0;
    localparam int ST_LOCK_BIT  = 2;
    localparam int ST_SYS_BIT   = 3;
    localparam int ST_EXT_LSB   = 8;
    localparam int STATUS_W     = 11;
    // source select codes
    localparam logic [1:0] SRC_SLOW = 2'h0;
    localparam logic [1:0] SRC_MAIN = 2'h1;
    localparam logic [1:0] SRC_PLL  = 2'h3;
    // reset values and counts
    localparam logic [5:0] PLL_SETTLE_RESET = 6'h3F;
    localparam logic [2:0] XTAL_PRESCALE_END = 3'h7;  // slow clock / 8
    localparam logic [3:0] MEAS_LAST_PERIOD  = 4'hF;  // sixteen slow periods
    localparam logic [1:0] SETTLE_LAST_EDGE  = 2'h1;  // two edges of new source
    localparam int         EXT_N = 3;
    // system clock switch state
    typedef enum logic [2:0] {
        ST_READY   = 3'h1,
        ST_SETTLE  = 3'h2,
        ST_PLLWAIT = 3'h4
    } sys_state_t;
endpackage : clock_manager_pkg
`default_nettype wire

/* File: design/system_clock_manager.sv */
// module: clock select, division, gating and start-up sequencing
// What this block does
// R01: system clock is selected source over 2^n, ratio 7 dividing by 64 like ratio 6
// R02: config write clears ready until clock established
// R03: cpu clock on at reset, interrupt wakes
// R04: cpu stops after instruction, bus keeps running
// R05: write 1 gates clock, 0 no effect
// R06: peripheral clocks gated singly, off at reset
// R07: peripheral bit position equals peripheral identifier
// R08: software idles peripheral before gating off
// R09: three external outputs with own source
// R10: external outputs divide by power of two
// R11: external ready flag shows programmed output
// R12: software disables output before reconfiguring it
// R13: oscillator enable bit starts crystal with delay
// R14: start delay counts slow clock over eight
// R15: software waits for crystal stable flag
// R16: frequency count is main edges in sixteen periods
// R17: pll input ratio zero turns divider off
// R18: pll factor zero off, else times factor+1
// R19: pll settled after settle-delay slow cycles
// R20: pll change drops settled flag until lock
// R21: software waits for settled before using pll
// R22: reset selects slow clock, ratio one
// R23: software waits ready after system clock change
// R24: reprogrammed pll forces main clock, ready low
// R25: masked ready flags combine onto interrupt
`default_nettype none
module system_clock_manager
    import clock_manager_pkg::*;
#(
    parameter int PERIPH_N = 32
) (
    // clock and reset
    input  wire logic                CLK_SYS,
    input  wire logic                RST,
    // apb slave
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [7:0]          PADDR,
    input  wire logic [31:0]         PWDATA,
    output var  logic [31:0]         PRDATA,
    output var  logic                PREADY,
    output var  logic                PSLVERR,
    // clock sources, sampled levels
    input  wire logic                LOW_SPEED_CLOCK,
    input  wire logic                MAIN_CLOCK,
    input  wire logic                PLL_CLOCK,
    // processor handshake
    input  wire logic                INSN_DONE,
    input  wire logic                FAST_IRQ,
    input  wire logic                NORMAL_IRQ,
    // generated clocks
    output var  logic                SYSTEM_CLOCK,
    output var  logic                CPU_CLOCK,
    output var  logic [PERIPH_N-1:0] PERIPH_CLOCK,
    output var  logic [EXT_N-1:0]    EXT_CLOCK_OUT,
    // analog controls and interrupt
    output var  logic                CRYSTAL_OSC_ENABLE,
    output var  logic [7:0]          PLL_RATIO,
    output var  logic [10:0]         PLL_FACTOR,
    output var  logic                IRQ
);
    typedef struct packed {
        logic                       pready;
        logic                       pslverr;
        logic [31:0]                prdata;
        logic [2:0]                 src_prev;
        logic [1:0]                 sys_src;
        logic [2:0]                 sys_ratio;
        logic [5:0]                 sys_cnt;
        logic                       sys_clk;
        sys_state_t                 sc;
        logic [1:0]                 sc_wait;
        logic                       sys_ready;
        logic                       cpu_on;
        logic                       cpu_run;
        logic                       cpu_clk;
        logic [PERIPH_N-1:0]        periph_on;
        logic [PERIPH_N-1:0]        periph_clk;
        logic [EXT_N-1:0]           ext_on;
        logic [EXT_N-1:0][1:0]      ext_src;
        logic [EXT_N-1:0][2:0]      ext_ratio;
        logic [EXT_N-1:0][5:0]      ext_cnt;
        logic [EXT_N-1:0][1:0]      ext_wait;
        logic [EXT_N-1:0]           ext_ready;
        logic [EXT_N-1:0]           ext_clk;
        logic                       osc_en;
        logic [7:0]                 osc_delay;
        logic [7:0]                 osc_count;
        logic [2:0]                 osc_pre;
        logic                       xtal_stable;
        logic                       meas_run;
        logic [3:0]                 meas_period;
        logic [15:0]                freq_count;
        logic                       meas_done;
        logic [7:0]                 pll_ratio;
        logic [10:0]                pll_factor;
        logic [5:0]                 pll_delay;
        logic [5:0]                 pll_count;
        logic                       lock;
        logic [STATUS_W-1:0]        imr;
        logic                       irq;
    } state_t;

    state_t                st;
    state_t                next_st;
    logic                  setup_cycle;
    logic                  wr_cycle;
    logic                  pll_live;
    logic                  pll_src;
    logic [2:0]            src_now;
    logic [2:0]            src_rise;
    logic [1:0]            sys_eff;
    logic                  sys_rise;
    logic [STATUS_W-1:0]   status;

    // picks one of slow, main, pll by a source code
    function automatic logic pick(input logic [1:0] sel, input logic [2:0] v);
        case (sel)
            SRC_SLOW: pick = v[0];
            SRC_MAIN: pick = v[1];
            SRC_PLL:  pick = v[2];
            default:  pick = 1'b0;
        endcase
    endfunction : pick

    // power-of-two divider tap; ratio 0 passes the source through
    function automatic logic tap(input logic [5:0] cnt, input logic [2:0] ratio,
                                 input logic src);
        case (ratio)
            3'h0:    tap = src;
            3'h1:    tap = cnt[0];
            3'h2:    tap = cnt[1];
            3'h3:    tap = cnt[2];
            3'h4:    tap = cnt[3];
            3'h5:    tap = cnt[4];
            default: tap = cnt[5];
        endcase
    endfunction : tap

    // status word as read and as used for the interrupt
    always_comb begin
        status = '0;
        status[ST_XTAL_BIT] = st.xtal_stable;
        status[ST_LOCK_BIT] = st.lock;
        status[ST_SYS_BIT] = st.sys_ready;
        status[ST_EXT_LSB +: EXT_N] = st.ext_ready;
    end

    // next state of the whole block
    always_comb begin
        next_st = st;
        setup_cycle = PSEL & ~PENABLE & ~st.pready;
        wr_cycle = PSEL & PENABLE & PWRITE & st.pready;
        pll_live = (st.pll_ratio != 8'h00) && (st.pll_factor != 11'h000); // R17 R18
        pll_src = PLL_CLOCK & pll_live;
        src_now = {pll_src, MAIN_CLOCK, LOW_SPEED_CLOCK};
        src_rise = src_now & ~st.src_prev;
        next_st.src_prev = src_now;
        // unlocked pll feeds main clock to the system instead
        sys_eff = (st.sys_src == SRC_PLL && !st.lock) ? SRC_MAIN : st.sys_src; // R24
        sys_rise = pick(sys_eff, src_rise);

        // system clock divider
        if (sys_rise) begin
            next_st.sys_cnt = st.sys_cnt + 6'h01;
        end
        next_st.sys_clk = tap(next_st.sys_cnt, st.sys_ratio, pick(sys_eff, src_now)); // R01
        // cpu clock stops only once the running instruction ends
        if (st.cpu_on) begin
            next_st.cpu_run = 1'b1;
        end else if (INSN_DONE) begin
            next_st.cpu_run = 1'b0; // R04
        end
        if (FAST_IRQ || NORMAL_IRQ) begin
            next_st.cpu_on = 1'b1; // R03
        end
        // bus masters keep the system clock while the cpu idles
        next_st.cpu_clk = next_st.sys_clk & st.cpu_run; // R04
        next_st.periph_clk = {PERIPH_N{next_st.sys_clk}} & st.periph_on; // R06

        // system clock ready sequencing
        case (st.sc)
            ST_READY: begin
                next_st.sc_wait = 2'h0;
            end
            ST_SETTLE: begin
                if (sys_rise) begin
                    if (st.sc_wait == SETTLE_LAST_EDGE) begin
                        next_st.sc = ST_READY;
                        next_st.sys_ready = 1'b1; // R02
                    end else begin
                        next_st.sc_wait = st.sc_wait + 2'h1;
                    end
                end
            end
            ST_PLLWAIT: begin
                if (st.lock) begin
                    next_st.sc = ST_SETTLE; // R24
                    next_st.sc_wait = 2'h0;
                end
            end
            default: begin
                next_st.sc = ST_SETTLE;
            end
        endcase

        // external clock outputs
        for (int i = 0; i < EXT_N; i++) begin
            if (pick(st.ext_src[i], src_rise)) begin
                next_st.ext_cnt[i] = st.ext_cnt[i] + 6'h01;
            end
            next_st.ext_clk[i] = st.ext_on[i] &
                tap(next_st.ext_cnt[i], st.ext_ratio[i], pick(st.ext_src[i], src_now)); // R09 R10
            if (!st.ext_on[i]) begin
                next_st.ext_ready[i] = 1'b0;
                next_st.ext_wait[i] = 2'h0;
            end else if (!st.ext_ready[i] && pick(st.ext_src[i], src_rise)) begin
                if (st.ext_wait[i] == SETTLE_LAST_EDGE) begin
                    next_st.ext_ready[i] = 1'b1; // R11
                end else begin
                    next_st.ext_wait[i] = st.ext_wait[i] + 2'h1;
                end
            end
        end

        // crystal start-up count on slow clock over eight
        if (!st.osc_en) begin
            next_st.xtal_stable = 1'b0;
        end else if (!st.xtal_stable && src_rise[0]) begin
            next_st.osc_pre = st.osc_pre + 3'h1;
            if (st.osc_pre == XTAL_PRESCALE_END) begin
                // the tick at count one sets the flag instead of decrementing, so delay n costs n periods
                if (st.osc_count <= 8'h01) begin
                    next_st.xtal_stable = 1'b1; // R14
                end else begin
                    next_st.osc_count = st.osc_count - 8'h01;
                end
            end
        end

        // main clock frequency measurement
        if (!st.xtal_stable) begin
            next_st.meas_run = 1'b0;
            next_st.meas_done = 1'b0;
        end else if (st.meas_run) begin
            if (src_rise[1]) begin
                next_st.freq_count = st.freq_count + 16'h0001; // R16
            end
            if (src_rise[0]) begin
                next_st.meas_period = st.meas_period + 4'h1;
                if (st.meas_period == MEAS_LAST_PERIOD) begin
                    next_st.meas_run = 1'b0;
                    next_st.meas_done = 1'b1; // R16
                end
            end
        end else if (!st.meas_done && src_rise[0]) begin
            next_st.meas_run = 1'b1;
            next_st.meas_period = 4'h0;
            next_st.freq_count = 16'h0000;
        end

        // pll settle count on slow clock
        if (!st.lock && src_rise[0]) begin
            // settle field n gives lock after n slow edges
            if (st.pll_count <= 6'h01) begin
                next_st.lock = 1'b1; // R19
            end else begin
                next_st.pll_count = st.pll_count - 6'h01;
            end
        end

        // interrupt from set and unmasked flags
        next_st.irq = |(status & st.imr); // R25

        // apb answer, one wait-free access phase
        next_st.pready = setup_cycle;
        next_st.pslverr = 1'b0;
        if (setup_cycle) begin
            next_st.prdata = 32'h0000_0000;
            case (PADDR)
                SYSCLK_GATE_ON_REG, SYSCLK_GATE_OFF_REG, PERIPH_GATE_ON_REG,
                PERIPH_GATE_OFF_REG, CLOCK_IRQ_ENABLE_REG, CLOCK_IRQ_DISABLE_REG: begin
                    next_st.prdata = 32'h0000_0000;
                end
                SYSCLK_GATE_STATE_REG: begin
                    next_st.prdata[CPU_BIT] = st.cpu_on; // R05
                    next_st.prdata[EXT_LSB +: EXT_N] = st.ext_on;
                end
                PERIPH_GATE_STATE_REG: next_st.prdata[PERIPH_N-1:0] = st.periph_on; // R07
                CRYSTAL_OSC_REG: begin
                    next_st.prdata[OSC_EN_BIT] = st.osc_en;
                    next_st.prdata[OSC_CNT_LSB +: 8] = st.osc_delay;
                end
                FREQ_MEAS_REG: begin
                    next_st.prdata[15:0] = st.freq_count;
                    next_st.prdata[MEAS_RDY_BIT] = st.meas_done;
                end
                PLL_CONFIG_REG: begin
                    next_st.prdata[PLL_RAT_LSB +: 8] = st.pll_ratio;
                    next_st.prdata[PLL_CNT_LSB +: 6] = st.pll_delay;
                    next_st.prdata[PLL_FAC_LSB +: 11] = st.pll_factor;
                end
                SYSCLK_CONFIG_REG: begin
                    next_st.prdata[SRC_LSB +: 2] = st.sys_src;
                    next_st.prdata[RATIO_LSB +: 3] = st.sys_ratio;
                end
                EXT_CLOCK_CONFIG_REG0, EXT_CLOCK_CONFIG_REG1, EXT_CLOCK_CONFIG_REG2: begin
                    next_st.prdata[SRC_LSB +: 2] = st.ext_src[PADDR[3:2]];
                    next_st.prdata[RATIO_LSB +: 3] = st.ext_ratio[PADDR[3:2]];
                end
                CLOCK_STATUS_REG:   next_st.prdata[STATUS_W-1:0] = status;
                CLOCK_IRQ_MASK_REG: next_st.prdata[STATUS_W-1:0] = st.imr;
                default:            next_st.pslverr = 1'b1;
            endcase
        end

        // register writes; a write's own clear overrides the hardware set, except an interrupt beats a cpu gate-off write
        if (wr_cycle) begin
            case (PADDR)
                SYSCLK_GATE_ON_REG: begin
                    next_st.cpu_on = st.cpu_on | PWDATA[CPU_BIT]; // R05
                    next_st.ext_on = st.ext_on | PWDATA[EXT_LSB +: EXT_N];
                end
                SYSCLK_GATE_OFF_REG: begin
                    if (PWDATA[CPU_BIT] && !(FAST_IRQ || NORMAL_IRQ)) begin
                        next_st.cpu_on = 1'b0; // R03
                    end
                    next_st.ext_on = st.ext_on & ~PWDATA[EXT_LSB +: EXT_N]; // R05
                end
                PERIPH_GATE_ON_REG: next_st.periph_on = st.periph_on | PWDATA[PERIPH_N-1:0]; // R06
                PERIPH_GATE_OFF_REG: next_st.periph_on = st.periph_on & ~PWDATA[PERIPH_N-1:0]; // R06
                CRYSTAL_OSC_REG: begin
                    next_st.osc_en = PWDATA[OSC_EN_BIT]; // R13
                    next_st.osc_delay = PWDATA[OSC_CNT_LSB +: 8];
                    next_st.osc_count = PWDATA[OSC_CNT_LSB +: 8]; // R14
                    next_st.osc_pre = 3'h0;
                    next_st.xtal_stable = 1'b0; // R14
                end
                PLL_CONFIG_REG: begin
                    next_st.pll_ratio = PWDATA[PLL_RAT_LSB +: 8]; // R17
                    next_st.pll_factor = PWDATA[PLL_FAC_LSB +: 11]; // R18
                    next_st.pll_delay = PWDATA[PLL_CNT_LSB +: 6];
                    next_st.pll_count = PWDATA[PLL_CNT_LSB +: 6]; // R19
                    next_st.lock = 1'b0; // R20
                    if (st.sys_src == SRC_PLL) begin
                        next_st.sys_ready = 1'b0; // R24
                        next_st.sc = ST_PLLWAIT;
                    end
                end
                SYSCLK_CONFIG_REG: begin
                    next_st.sys_src = PWDATA[SRC_LSB +: 2]; // R01
                    next_st.sys_ratio = PWDATA[RATIO_LSB +: 3];
                    next_st.sys_ready = 1'b0; // R02
                    next_st.sc_wait = 2'h0;
                    next_st.sc = (PWDATA[SRC_LSB +: 2] == SRC_PLL) ? ST_PLLWAIT : ST_SETTLE;
                end
                EXT_CLOCK_CONFIG_REG0, EXT_CLOCK_CONFIG_REG1, EXT_CLOCK_CONFIG_REG2: begin
                    next_st.ext_src[PADDR[3:2]] = PWDATA[SRC_LSB +: 2]; // R09
                    next_st.ext_ratio[PADDR[3:2]] = PWDATA[RATIO_LSB +: 3]; // R10
                    next_st.ext_ready[PADDR[3:2]] = 1'b0; // R11
                    next_st.ext_wait[PADDR[3:2]] = 2'h0;
                end
                CLOCK_IRQ_ENABLE_REG: next_st.imr = st.imr | PWDATA[STATUS_W-1:0]; // R25
                CLOCK_IRQ_DISABLE_REG: next_st.imr = st.imr & ~PWDATA[STATUS_W-1:0]; // R25
                default: begin
                    next_st.imr = next_st.imr;
                end
            endcase
        end
    end

    // state register; reset gives slow clock, ratio one, cpu on
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st           <= '0;
            st.sys_src   <= SRC_SLOW; // R22
            st.sys_ratio <= 3'h0; // R22
            st.sc        <= ST_READY;
            st.sys_ready <= 1'b1;
            st.cpu_on    <= 1'b1; // R03
            st.cpu_run   <= 1'b1;
            st.pll_delay <= PLL_SETTLE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign PRDATA = st.prdata;
    assign PREADY = st.pready;
    assign PSLVERR = st.pslverr;
    assign SYSTEM_CLOCK = st.sys_clk;
    assign CPU_CLOCK = st.cpu_clk;
    assign PERIPH_CLOCK = st.periph_clk;
    assign EXT_CLOCK_OUT = st.ext_clk;
    assign CRYSTAL_OSC_ENABLE = st.osc_en;
    assign PLL_RATIO = st.pll_ratio;
    assign PLL_FACTOR = st.pll_factor;
    assign IRQ = st.irq;

    // checks
    property p_sys_clear;
        @(posedge CLK_SYS) disable iff (RST)
        (wr_cycle && PADDR == SYSCLK_CONFIG_REG) |=> !st.sys_ready ##1 !st.sys_ready;
    endproperty
    a_sys_clear: assert property (p_sys_clear) else $error("ready not cleared"); // R02

    property p_cpu_wake;
        @(posedge CLK_SYS) disable iff (RST)
        (FAST_IRQ || NORMAL_IRQ) |=> st.cpu_on ##1 st.cpu_run;
    endproperty
    a_cpu_wake: assert property (p_cpu_wake) else $error("cpu not woken"); // R03

    property p_cpu_finish;
        @(posedge CLK_SYS) disable iff (RST)
        (st.cpu_run && !INSN_DONE) |=> st.cpu_run;
    endproperty
    a_cpu_finish: assert property (p_cpu_finish) else $error("cpu stopped early"); // R04

    property p_periph_off;
        @(posedge CLK_SYS) disable iff (RST)
        (wr_cycle && PADDR == PERIPH_GATE_OFF_REG && PWDATA[0])
            |=> !st.periph_on[0] ##1 !PERIPH_CLOCK[0];
    endproperty
    a_periph_off: assert property (p_periph_off) else $error("clock not gated"); // R06

    property p_gate_zero;
        @(posedge CLK_SYS) disable iff (RST)
        (wr_cycle && PADDR == PERIPH_GATE_ON_REG && !PWDATA[1])
            |=> st.periph_on[1] == $past(st.periph_on[1]);
    endproperty
    a_gate_zero: assert property (p_gate_zero) else $error("zero write acted"); // R05

    property p_osc_clear;
        @(posedge CLK_SYS) disable iff (RST)
        (wr_cycle && PADDR == CRYSTAL_OSC_REG) |=> !st.xtal_stable [*2];
    endproperty
    a_osc_clear: assert property (p_osc_clear) else $error("stable not cleared"); // R14

    property p_pll_drop;
        @(posedge CLK_SYS) disable iff (RST)
        (wr_cycle && PADDR == PLL_CONFIG_REG) |=> !st.lock;
    endproperty
    a_pll_drop: assert property (p_pll_drop) else $error("lock not dropped"); // R20

    property p_pll_set;
        @(posedge CLK_SYS) disable iff (RST)
        $rose(st.lock) |-> ($past(st.pll_count) <= 6'h01 && $past(src_rise[0]));
    endproperty
    a_pll_set: assert property (p_pll_set) else $error("lock set early"); // R19

    property p_pll_fallback;
        @(posedge CLK_SYS) disable iff (RST)
        (st.sys_src == SRC_PLL && !st.lock) |-> (!st.sys_ready && sys_eff == SRC_MAIN);
    endproperty
    a_pll_fallback: assert property (p_pll_fallback) else $error("no main fallback"); // R24

    property p_irq;
        @(posedge CLK_SYS) disable iff (RST)
        1'b1 |=> IRQ == $past(|(status & st.imr));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt mismatch"); // R25
endmodule : system_clock_manager
`default_nettype wire

/* File: dv/clock_partner.sv */
// partner: source clocks and instruction handshake of the core
`default_nettype none
module clock_partner (
    // clock, reset
    input  wire logic clk,
    input  wire logic rst,
    // outputs
    output var  logic slow,
    output var  logic mclk,
    output var  logic done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt;
    // slow is clk/8, main is clk/4
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 3'h0;
        end else begin
            cnt <= cnt + 3'h1;
        end
    end
    assign slow = cnt[2];
    assign mclk = cnt[1];
    assign done = &cnt[1:0];
endmodule : clock_partner
`default_nettype wire

/* File: dv/system_clock_manager_tb_top.sv */
// testbench: registers, gating and start-up flags
`default_nettype none
module system_clock_manager_tb_top import clock_manager_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, psel, pen, pwr, rdy, err, slow, mclk, done, firq;
    logic nirq, se, sysc, cpuc, osce, irqo;
    logic [2:0] extc;
    logic [7:0] pa, prat, seen;
    logic [10:0] pfac;
    logic [31:0] pwd, prd, rd, perc;
    int mismatches, samples_checked, rises;
    system_clock_manager i_dut (.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
        .LOW_SPEED_CLOCK(slow), .MAIN_CLOCK(mclk), .PLL_CLOCK(mclk), .INSN_DONE(done),
        .FAST_IRQ(firq), .NORMAL_IRQ(nirq), .SYSTEM_CLOCK(sysc), .CPU_CLOCK(cpuc),
        .PERIPH_CLOCK(perc), .EXT_CLOCK_OUT(extc), .CRYSTAL_OSC_ENABLE(osce),
        .PLL_RATIO(prat), .PLL_FACTOR(pfac), .IRQ(irqo));
    clock_partner i_cpu (.clk(clk), .rst(rst), .slow(slow), .mclk(mclk), .done(done));
    // one apb transfer, read data left in rd
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = prd;
        se = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask : check
    // gated clocks seen high, and system clock rises, over w cycles
    task automatic watch(input int w);
        logic p;
        p = sysc;
        seen = 8'h00;
        rises = 0;
        repeat (w) begin
            @(posedge clk);
            rises += int'(sysc & ~p);
            p = sysc;
            seen |= {sysc, irqo, extc, cpuc, perc[8], perc[4]};
        end
    endtask : watch
    // poll one flag with a bounded count
    task automatic wait_flag(input logic [7:0] a, input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 300);
        check("flag", 32'h1, {31'h0, rd[b]});
    endtask : wait_flag
    task automatic test_reset();
        apb(1'b0, SYSCLK_GATE_STATE_REG, 32'h0);
        check("cpu on", 32'h1, rd);
        apb(1'b0, PERIPH_GATE_STATE_REG, 32'h0);
        check("periph", 32'h0, rd);
        apb(1'b0, SYSCLK_CONFIG_REG, 32'h0);
        check("sys cfg", 32'h0, rd);
        apb(1'b0, PLL_CONFIG_REG, 32'h0);
        check("pll cfg", 32'h3F00, rd);
        apb(1'b0, 8'h0C, 32'h0);
        check("unmapped", 32'h1, {31'h0, se});
    endtask : test_reset
    task automatic test_gates();
        apb(1'b1, PERIPH_GATE_ON_REG, 32'h110);
        apb(1'b1, PERIPH_GATE_OFF_REG, 32'h10);
        apb(1'b0, PERIPH_GATE_STATE_REG, 32'h0);
        check("periph", 32'h100, rd);
        watch(16);
        check("gates", 32'h86, {24'h0, seen});
        check("sys rises", 32'h2, rises);
        apb(1'b1, SYSCLK_GATE_OFF_REG, 32'h1);
        apb(1'b0, SYSCLK_GATE_STATE_REG, 32'h0);
        check("cpu idle", 32'h0, rd);
        repeat (8) @(posedge clk);
        watch(16);
        check("idle clocks", 32'h82, {24'h0, seen});
        firq <= 1'b1;
        apb(1'b0, SYSCLK_GATE_STATE_REG, 32'h0);
        check("cpu wake", 32'h1, rd);
        firq <= 1'b0;
        apb(1'b1, SYSCLK_GATE_OFF_REG, 32'h1);
        nirq <= 1'b1;
        apb(1'b0, SYSCLK_GATE_STATE_REG, 32'h0);
        check("cpu wake normal", 32'h1, rd);
        nirq <= 1'b0;
    endtask : test_gates
    // write, see flag drop, wait for it to return
    task automatic test_seq(input logic [7:0] a, input logic [31:0] d, input int b);
        apb(1'b1, a, d);
        apb(1'b0, CLOCK_STATUS_REG, 32'h0);
        check("flag low", 32'h0, {31'h0, rd[b]});
        wait_flag(CLOCK_STATUS_REG, b);
    endtask : test_seq
    // external output programmed while off, then enabled
    task automatic test_ext();
        apb(1'b1, EXT_CLOCK_CONFIG_REG0, 32'h5);
        apb(1'b1, SYSCLK_GATE_ON_REG, 32'h100);
        apb(1'b0, SYSCLK_GATE_STATE_REG, 32'h0);
        check("gate state", 32'h101, rd);
        wait_flag(CLOCK_STATUS_REG, ST_EXT_LSB);
        apb(1'b1, CLOCK_IRQ_ENABLE_REG, 32'h8);
        watch(16);
        check("outputs", 32'hCE, {24'h0, seen});
    endtask : test_ext
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #2000000;
        mismatches++;
        complete_run();
    end
    initial begin
        {rst, psel, pen, pwr, firq, nirq, pa, pwd} = {6'h20, 8'h0, 32'h0};
        mismatches = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_gates();
        test_seq(SYSCLK_CONFIG_REG, 32'h5, ST_SYS_BIT);
        watch(64);
        check("sys rises", 32'h8, rises);
        test_seq(CRYSTAL_OSC_REG, 32'h101, ST_XTAL_BIT);
        check("osc en", 32'h1, {31'h0, osce});
        wait_flag(FREQ_MEAS_REG, MEAS_RDY_BIT);
        check("meas count", 32'h20, {16'h0, rd[15:0]});
        test_seq(PLL_CONFIG_REG, 32'h10201, ST_LOCK_BIT);
        check("pll out", 32'h101, {13'h0, pfac, prat});
        test_seq(SYSCLK_CONFIG_REG, 32'h3, ST_SYS_BIT);
        test_seq(PLL_CONFIG_REG, 32'h10201, ST_SYS_BIT);
        test_ext();
        complete_run();
    end
endmodule : system_clock_manager_tb_top
`default_nettype wire
